// file: verilog/txp_cfg.svh
// Offsets, field positions, reset values and timing counts of the transmit input block
`ifndef TXP_CFG_SVH
`define TXP_CFG_SVH

// ----------------------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------------------
`define TXP_ADDR_W 12
`define TXP_CTRL_ADDR 12'h000
`define TXP_STAT_ADDR 12'h004

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define TXP_CTRL_TXCKSEL 0
`define TXP_CTRL_RECENTER 1
`define TXP_CTRL_SELFTEST 2
`define TXP_CTRL_RXCKSEL 3
`define TXP_CTRL_OE1 4
`define TXP_CTRL_OE2 5
`define TXP_CTRL_BYPASS 6
`define TXP_CTRL_HALFRATE 7
`define TXP_CTRL_RXREF 8
`define TXP_CTRL_W 9
`define TXP_CTRL_RESET 9'h036

// ----------------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------------
`define TXP_STAT_ERR 0
`define TXP_STAT_BUFERR 1
`define TXP_STAT_REFLOST 2
`define TXP_STAT_PLLDOWN 3
`define TXP_STAT_LEVEL_LSB 4
`define TXP_STAT_CHAR_LSB 8
`define TXP_STAT_KIND_LSB 16

// ----------------------------------------------------------------------------
// Self-test pass periods in character times
// ----------------------------------------------------------------------------
`define TXP_BIST_W 10
`define TXP_BIST_PERIOD_RX1 10'h20F
`define TXP_BIST_PERIOD_RX0 10'h1FF

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define TXP_PCLK_NS 20
`define TXP_REF_LOSS_NS 2000
`define TXP_REF_LOSS_CYC (`TXP_REF_LOSS_NS / `TXP_PCLK_NS)
`define TXP_REF_CNT_W 8

`endif

// file: verilog/txp_pkg.sv
// Types shared by the transmit input block
package txp_pkg;

  // Meaning of the two control inputs with the encoder enabled
  typedef enum logic [1:0] {
    TXP_KIND_DATA = 2'h0,
    TXP_KIND_SPECIAL = 2'h1,
    TXP_KIND_WORD_SYNC = 2'h2,
    TXP_KIND_REPLACE = 2'h3
  } txp_kind_t;

endpackage : txp_pkg

// file: verilog/txp_tx_input.sv
// Parallel transmit input, phase align buffer and transmit error output of one channel
`timescale 1ns/1ps
`include "txp_cfg.svh"
module txp_tx_input #(
  parameter int DEPTH = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`TXP_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_input_clock,
  input wire logic chan_reference_clock,
  input wire logic recovered_rx_clock,
  input wire logic [7:0] tx_char_data_in,
  input wire logic [1:0] tx_char_ctrl_in,
  output logic tx_path_error_out,
  output logic [7:0] enc_char,
  output txp_pkg::txp_kind_t enc_kind,
  output logic [9:0] shift_word,
  output logic char_strobe,
  output logic enc_bypass
);

  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] HALF = (PW + 1)'(DEPTH / 2);
  localparam logic [PW:0] FULLC = (PW + 1)'(DEPTH);

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic [12:0] pin_s1_q;
  logic [12:0] pin_s2_q;
  logic [2:0] clk_prev_q;
  wire logic txclk_s = pin_s2_q[0];
  wire logic ref_s = pin_s2_q[1];
  wire logic rxclk_s = pin_s2_q[2];
  wire logic [7:0] data_s = pin_s2_q[10:3];
  wire logic [1:0] ctrl_s = pin_s2_q[12:11];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_s1_q <= 13'h0000;
      pin_s2_q <= 13'h0000;
      clk_prev_q <= 3'h0;
    end
    else
    begin
      pin_s1_q <= {tx_char_ctrl_in, tx_char_data_in, recovered_rx_clock,
                   chan_reference_clock, tx_input_clock};
      pin_s2_q <= pin_s1_q;
      clk_prev_q <= pin_s2_q[2:0];
    end
  end

  // --------------------------------------------------------------------------
  // Control register
  // --------------------------------------------------------------------------
  logic [`TXP_CTRL_W-1:0] ctrl_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  wire logic sel_ref = ctrl_q[`TXP_CTRL_TXCKSEL];
  wire logic bist_mode = !ctrl_q[`TXP_CTRL_SELFTEST];
  wire logic rx_sel = ctrl_q[`TXP_CTRL_RXCKSEL];
  wire logic bypass = ctrl_q[`TXP_CTRL_BYPASS];
  wire logic half_rate = ctrl_q[`TXP_CTRL_HALFRATE];
  wire logic use_rx_ref = ctrl_q[`TXP_CTRL_RXREF];
  wire logic pll_down = !ctrl_q[`TXP_CTRL_OE1] && !ctrl_q[`TXP_CTRL_OE2];
  wire logic hit_ctrl = paddr == `TXP_CTRL_ADDR;
  wire logic hit_stat = paddr == `TXP_STAT_ADDR;
  wire logic apb_setup = psel && !penable;
  wire logic apb_wr = psel && penable && pready_q && pwrite && hit_ctrl;
  wire logic recenter = apb_wr && !pwdata[`TXP_CTRL_RECENTER];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_q <= `TXP_CTRL_RESET;
    else if (apb_wr)
      ctrl_q <= pwdata[`TXP_CTRL_W-1:0];
  end

  // --------------------------------------------------------------------------
  // Clock edge events
  // --------------------------------------------------------------------------
  wire logic ref_pin_s = use_rx_ref ? rxclk_s : ref_s;
  wire logic ref_prev = use_rx_ref ? clk_prev_q[2] : clk_prev_q[1];
  wire logic ref_rise = ref_pin_s && !ref_prev;
  wire logic ref_fall = !ref_pin_s && ref_prev;
  // One character time per reference rise, or per edge in half rate
  wire logic char_evt = ref_rise || (half_rate && ref_fall);
  wire logic txclk_rise = txclk_s && !clk_prev_q[0];
  wire logic in_evt = sel_ref ? char_evt : txclk_rise;

  // --------------------------------------------------------------------------
  // Reference clock presence
  // --------------------------------------------------------------------------
  logic [`TXP_REF_CNT_W-1:0] ref_cnt_q;
  logic ref_lost_q;
  wire logic ref_edge = ref_rise || ref_fall;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ref_cnt_q <= '0;
      ref_lost_q <= 1'b1;
    end
    else if (ref_edge)
    begin
      ref_cnt_q <= '0;
      ref_lost_q <= 1'b0;
    end
    else if (ref_cnt_q == `TXP_REF_CNT_W'(`TXP_REF_LOSS_CYC))
      ref_lost_q <= 1'b1;
    else
      ref_cnt_q <= ref_cnt_q + 1'b1;
  end

  // --------------------------------------------------------------------------
  // Phase align buffer (used only with the input clock selected)
  // --------------------------------------------------------------------------
  logic [9:0] buf_mem [DEPTH];
  logic [PW-1:0] wptr_q;
  logic [PW-1:0] rptr_q;
  logic [PW:0] level_q;
  wire logic buf_full = level_q == FULLC;
  wire logic buf_empty = level_q == '0;
  wire logic push_try = in_evt && !sel_ref;
  wire logic pop_try = char_evt && !sel_ref;
  wire logic overflow = push_try && buf_full && !pop_try;
  wire logic underflow = pop_try && buf_empty;
  wire logic push = push_try && !overflow;
  wire logic pop = pop_try && !buf_empty;
  wire logic [9:0] head = buf_mem[rptr_q];
  wire logic [9:0] in_word = {ctrl_s, data_s};

  always_ff @(posedge pclk)
  begin
    if (push)
      buf_mem[wptr_q] <= in_word;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wptr_q <= PW'(HALF);
      rptr_q <= '0;
      level_q <= HALF;
    end
    else if (recenter)
    begin
      // Restart half full so both clocks get equal drift margin
      wptr_q <= PW'(rptr_q + PW'(HALF));
      level_q <= HALF;
    end
    else
    begin
      if (push)
        wptr_q <= wptr_q + 1'b1;
      if (pop)
        rptr_q <= rptr_q + 1'b1;
      level_q <= level_q + (PW + 1)'(push) - (PW + 1)'(pop);
    end
  end

  // --------------------------------------------------------------------------
  // Character forwarding to encoder or shifter
  // --------------------------------------------------------------------------
  wire logic [9:0] out_word = sel_ref ? in_word : head;
  wire logic out_go = sel_ref ? char_evt : pop;
  wire txp_pkg::txp_kind_t out_kind = txp_pkg::txp_kind_t'(out_word[9:8]);
  wire logic sync_sent = out_go && !bypass && out_kind == txp_pkg::TXP_KIND_WORD_SYNC;
  logic [7:0] enc_char_q;
  txp_pkg::txp_kind_t enc_kind_q;
  logic [9:0] shift_word_q;
  logic strobe_q;
  logic bypass_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enc_char_q <= 8'h00;
      enc_kind_q <= txp_pkg::TXP_KIND_DATA;
      shift_word_q <= 10'h000;
      strobe_q <= 1'b0;
      bypass_q <= 1'b0;
    end
    else
    begin
      strobe_q <= out_go;
      bypass_q <= bypass;
      if (out_go && !bypass)
      begin
        enc_char_q <= out_word[7:0];
        enc_kind_q <= out_kind;
      end
      if (out_go && bypass)
        shift_word_q <= out_word;
    end
  end

  // --------------------------------------------------------------------------
  // Buffer error, self-test pass pulse and error output
  // --------------------------------------------------------------------------
  logic buf_err_q;
  logic [`TXP_BIST_W-1:0] bist_cnt_q;
  logic bist_pulse_q;
  logic err_q;
  wire logic [`TXP_BIST_W-1:0] bist_period = rx_sel ? `TXP_BIST_PERIOD_RX1
                                                    : `TXP_BIST_PERIOD_RX0;
  wire logic bist_last = bist_cnt_q == bist_period - 1'b1;
  wire logic buf_evt = overflow || underflow;
  wire logic buf_clr = sync_sent || recenter;
  wire logic err_d = pll_down || ref_lost_q || (bist_mode ? bist_pulse_q : buf_err_q);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      buf_err_q <= 1'b0;
    else if (buf_evt)
      buf_err_q <= 1'b1;
    else if (buf_clr)
      buf_err_q <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bist_cnt_q <= '0;
      bist_pulse_q <= 1'b0;
    end
    else if (!bist_mode)
    begin
      bist_cnt_q <= '0;
      bist_pulse_q <= 1'b0;
    end
    else if (char_evt)
    begin
      // Pulse spans exactly one character time, edge to edge
      bist_pulse_q <= bist_last;
      bist_cnt_q <= bist_last ? '0 : bist_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      err_q <= 1'b1;
    else
      err_q <= err_d;
  end

  // --------------------------------------------------------------------------
  // APB answer: one wait-free access phase after setup
  // --------------------------------------------------------------------------
  wire logic [31:0] stat_word = {14'h0000, enc_kind_q, enc_char_q, 1'b0, 3'(level_q),
                                 pll_down, ref_lost_q, buf_err_q, err_q};
  wire logic [31:0] rd_word = hit_ctrl ? {23'h000000, ctrl_q} : hit_stat ? stat_word : 32'h0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end
    else
    begin
      pready_q <= apb_setup;
      pslverr_q <= apb_setup && !(hit_ctrl || (hit_stat && !pwrite));
      prdata_q <= (apb_setup && !pwrite) ? rd_word : 32'h00000000;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign tx_path_error_out = err_q;
  assign enc_char = enc_char_q;
  assign enc_kind = enc_kind_q;
  assign shift_word = shift_word_q;
  assign char_strobe = strobe_q;
  assign enc_bypass = bypass_q;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_last_char;
    bist_mode && char_evt && bist_last;
  endsequence

  sequence s_pulse_one_char;
    bist_pulse_q ##1 bist_pulse_q;
  endsequence

  chk_capture_data: assert property (sel_ref && char_evt && !bypass |=>
    enc_char_q == $past(data_s) && strobe_q)
    else $error("character not captured on interface clock");
  chk_capture_ctrl: assert property (sel_ref && char_evt && !bypass |=>
    enc_kind_q == txp_pkg::txp_kind_t'($past(ctrl_s)))
    else $error("control not captured on interface clock");
  chk_bypass_bits: assert property (char_evt && sel_ref && bypass |=>
    shift_word_q[9:8] == $past(ctrl_s))
    else $error("bypass lost control bits");
  chk_buf_error_set: assert property (buf_evt |=> buf_err_q)
    else $error("buffer fault did not raise error");
  chk_buf_error_hold: assert property (buf_err_q && !buf_clr |=> buf_err_q)
    else $error("buffer error dropped early");
  chk_pass_pulse: assert property (s_last_char |=> s_pulse_one_char)
    else $error("self-test pass pulse missing");
  chk_pass_period: assert property (bist_mode && char_evt && bist_pulse_q |->
    bist_cnt_q == '0)
    else $error("self-test period wrong");
  chk_pll_down: assert property (pll_down |=> tx_path_error_out)
    else $error("error low with transmit PLL down");
  chk_ref_loss: assert property (ref_lost_q |=> tx_path_error_out)
    else $error("error low with reference absent");
  chk_idle_low: assert property (!pll_down && !ref_lost_q && !bist_mode && !buf_err_q
    |=> !tx_path_error_out)
    else $error("error high with no cause");
  chk_recenter_level: assert property (recenter && !buf_evt |=> level_q == HALF && !buf_err_q)
    else $error("recenter did not reinitialise buffer");

endmodule : txp_tx_input

// file: testbench/txp_host_model.sv
// Host model: presents characters to the transmit input on the reference clock
`timescale 1ns/1ps
module txp_host_model (
  input wire logic ref_clk,
  input wire logic run,
  output logic tx_clk,
  output logic [7:0] data,
  output logic [1:0] ctrl
);
  logic [9:0] q[$];
  logic [9:0] last;
  logic run_q;
  logic valid_q;

  initial
  begin
    run_q = 1'b0;
    valid_q = 1'b0;
    last = 10'h000;
    data = 8'h00;
    ctrl = 2'h0;
  end

  // Gate flips while the clock is low, so the input clock never glitches
  assign tx_clk = ref_clk & run_q;

  // Change at the fall so the pins are steady around the capturing rise
  always @(negedge ref_clk)
  begin
    run_q <= run;
    valid_q <= (q.size() > 0);
    if (q.size() > 0)
      last = q.pop_front();
    else
      last = ~last;
    {ctrl, data} <= last;
  end

  always @(posedge ref_clk)
    if (valid_q)
      tb_top.exp_q.push_back({ctrl, data});
endmodule : txp_host_model

// file: testbench/tb_top.sv
// Self-checking bench of the transmit input block
`timescale 1ns/1ps
`include "txp_cfg.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [`TXP_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd, r;
  logic er, ref_clk, ref_on, rx_on, rx_clk, tx_run, tx_clk, strobe, byp, err, byp_mode;
  logic [7:0] data, enc_char;
  logic [1:0] ctrl;
  txp_pkg::txp_kind_t enc_kind;
  logic [9:0] shift_word, obs, expv;
  logic [9:0] exp_q[$];
  int n_fail, checks_done, i, j, per, ct;
  time t0, t1, t2;

  txp_tx_input dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_input_clock(tx_clk), .chan_reference_clock(ref_clk),
    .recovered_rx_clock(rx_clk), .tx_char_data_in(data), .tx_char_ctrl_in(ctrl),
    .tx_path_error_out(err), .enc_char(enc_char), .enc_kind(enc_kind),
    .shift_word(shift_word), .char_strobe(strobe), .enc_bypass(byp));
  txp_host_model host (.ref_clk(ref_clk), .run(tx_run), .tx_clk(tx_clk), .data(data),
    .ctrl(ctrl));

  // Recovered clock follows the reference but can be stopped on its own
  assign rx_clk = ref_clk & rx_on;
  initial pclk = 1'b0;
  always #10 pclk = ~pclk;
  // Link clock stands still while ref_on is low
  initial
  begin
    ref_clk = 1'b0;
    ref_on = 1'b0;
    #7;
    forever #80 if (ref_on) ref_clk = ~ref_clk;
  end

  // Scoreboard: oldest note against each forwarded character
  always @(posedge pclk)
    if (strobe === 1'b1 && exp_q.size() > 0)
    begin
      obs = byp_mode ? shift_word : {enc_kind, enc_char};
      expv = exp_q.pop_front();
      `CHK(obs, expv)
    end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 16; k++)
    begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 16) n_fail++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_err(input logic v, input int lim);
    int k;
    for (k = 0; k < lim && err !== v; k++) @(posedge pclk);
    `CHK(err, v)
  endtask : wait_err

  task automatic drain();
    int k;
    for (k = 0; k < 600 && (host.q.size() > 0 || host.valid_q || exp_q.size() > 0); k++)
      @(posedge pclk);
    `CHK(exp_q.size(), 0)
  endtask : drain

  initial
  begin
    #1_000_000;
    n_fail++;
    give_verdict();
  end

  initial
  begin
    {psel, penable, pwrite, presetn, tx_run, byp_mode} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    rx_on = 1'b1;
    n_fail = 0;
    checks_done = 0;
    void'($urandom(73987));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `TXP_CTRL_ADDR, 32'h0);
    `CHK(rd, {23'h000000, `TXP_CTRL_RESET})
    apb(1'b0, 12'h008, 32'h0);
    `CHK({er, rd}, {1'b1, 32'h0})
    apb(1'b1, `TXP_STAT_ADDR, 32'hFFFFFFFF);
    `CHK(er, 1'b1)
    wait_err(1'b1, 4);
    $display("test registers done");
    ref_on = 1'b1;
    tx_run <= 1'b1;
    repeat (20) @(posedge pclk);
    apb(1'b1, `TXP_CTRL_ADDR, 32'h034);
    apb(1'b1, `TXP_CTRL_ADDR, 32'h036);
    wait_err(1'b0, 300);
    tx_run <= 1'b0;
    wait_err(1'b1, 200);
    tx_run <= 1'b1;
    repeat (200) @(posedge pclk);
    `CHK(err, 1'b1)
    apb(1'b1, `TXP_CTRL_ADDR, 32'h034);
    apb(1'b1, `TXP_CTRL_ADDR, 32'h036);
    wait_err(1'b0, 100);
    $display("test phase buffer done");
    apb(1'b1, `TXP_CTRL_ADDR, 32'h037);
    for (i = 0; i < 16; i++)
    begin
      r = $urandom;
      host.q.push_back({i[1:0], r[7:0]});
    end
    drain();
    apb(1'b1, `TXP_CTRL_ADDR, 32'h077);
    byp_mode = 1'b1;
    for (i = 0; i < 8; i++)
    begin
      r = $urandom;
      host.q.push_back(r[9:0]);
    end
    drain();
    `CHK(byp, 1'b1)
    byp_mode = 1'b0;
    $display("test characters done");
    apb(1'b1, `TXP_CTRL_ADDR, 32'h007);
    wait_err(1'b1, 5);
    `CHK(byp, 1'b0)
    apb(1'b1, `TXP_CTRL_ADDR, 32'h015);
    apb(1'b1, `TXP_CTRL_ADDR, 32'h017);
    wait_err(1'b0, 5);
    ref_on = 1'b0;
    repeat (60) @(posedge pclk);
    `CHK(err, 1'b0)
    wait_err(1'b1, 70);
    apb(1'b0, `TXP_STAT_ADDR, 32'h0);
    `CHK(rd[3:0], 4'h5)
    ref_on = 1'b1;
    wait_err(1'b0, 30);
    apb(1'b1, `TXP_CTRL_ADDR, 32'h117);
    rx_on = 1'b0;
    wait_err(1'b1, 130);
    rx_on = 1'b1;
    wait_err(1'b0, 30);
    $display("test power and reference done");
    // Third pass runs half rate: one character per reference edge
    for (j = 0; j < 3; j++)
    begin
      per = (j == 1) ? 527 : 511;
      ct = (j == 2) ? 80 : 160;
      apb(1'b1, `TXP_CTRL_ADDR, 32'h033 | ((j == 1) ? 32'h008 : 32'h000)
          | ((j == 2) ? 32'h080 : 32'h000));
      wait_err(1'b1, 5000);
      wait_err(1'b0, 20);
      wait_err(1'b1, 5000);
      t0 = $time;
      wait_err(1'b0, 20);
      t1 = $time;
      wait_err(1'b1, 5000);
      t2 = $time;
      `CHK(t1 - t0, ct)
      `CHK(t2 - t0, per * ct)
    end
    $display("test self-test done");
    give_verdict();
  end
endmodule : tb_top
